// >>> vms_top.sv
// voltage monitor status path: sync, glitch filter, window mux, APB registers
//
// Function
// - Ten channels, each with an upper and a lower threshold detector, feed the sense interface.
// - Channels one to four sense differentially, channels five to nine single-ended.
// - A detector reports one above its threshold and zero otherwise.
// - The upper detector status of channels four and nine also goes to the fast output controller.
// - The window signal is the lower detector and not the upper detector.
// - A per-channel select puts either the filtered upper status or the window on output A.
// - In window mode output B still reports the lower detector unchanged.
// - With the filter on, pulses shorter than 64 us leave the filtered status unchanged.
// - With the filter on, each filtered transition follows the raw change by about 64 us.
// - With the filter off, the status still follows the raw change by about 16 us.
// - After reset the detectors calibrate and the filters are initialised before use.
// - No valid status is sent and no output control accepted before analog ready.
// - Hysteresis lets a detector rise only at the upper and fall only at the lower trip point.
// - Every detector status can be read by an external host.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "vms_defs.svh"
module vms_top #(
	parameter int unsigned GPO_WIDTH = `VMS_GPO_WIDTH,
	parameter int unsigned FILT_ON_CYC = `VMS_FILT_ON_US * `VMS_CLK_MHZ,
	parameter int unsigned FILT_OFF_CYC = `VMS_FILT_OFF_US * `VMS_CLK_MHZ
) (
	input wire logic CLK_SYS_IN,
	input wire logic NRST_IN,
	input wire vms_pkg::vms_cmp_t CMP_RAW_IN,
	input wire logic ANALOG_READY_IN,
	input wire logic [GPO_WIDTH-1:0] GPO_REQ_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	output vms_pkg::vms_cmp_t STATUS_OUT,
	output logic STATUS_VALID_OUT,
	output logic FAST_CH4_OUT,
	output logic FAST_CH9_OUT,
	output logic [GPO_WIDTH-1:0] GPO_OUT,
	output logic IRQ_OUT
);
	import vms_pkg::*;

	localparam int unsigned NCH = `VMS_CHANNELS;
	localparam int unsigned NCMP = 2 * NCH;
	localparam int unsigned CNT_W = $clog2(FILT_ON_CYC + 1);

	initial
	begin
		if (GPO_WIDTH < 1 || GPO_WIDTH > 32)
			$error("GPO_WIDTH must be 1 to 32");
		if (FILT_OFF_CYC < 1 || FILT_ON_CYC < FILT_OFF_CYC)
			$error("filter counts must satisfy 1 <= off <= on");
	end

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction : hit

	// reset release through two flops
	logic rst_m_q;
	logic rst_n_q;
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			rst_m_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_m_q <= 1'b1;
			rst_n_q <= rst_m_q;
		end
	end

	// analog detector and ready levels cross into the clock domain
	logic [NCMP-1:0] raw_m_q;
	logic [NCMP-1:0] raw_q;
	logic rdy_m_q;
	logic rdy_q;
	always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			raw_m_q <= '0;
			raw_q <= '0;
			rdy_m_q <= 1'b0;
			rdy_q <= 1'b0;
		end
		else
		begin
			raw_m_q <= CMP_RAW_IN;
			raw_q <= raw_m_q;
			rdy_m_q <= ANALOG_READY_IN;
			rdy_q <= rdy_m_q;
		end
	end

	vms_phase_t phase_q;
	vms_phase_t phase_d;
	always_comb
	begin
		unique case (phase_q)
			PH_CAL: phase_d = rdy_q ? PH_RUN : PH_CAL;
			PH_RUN: phase_d = rdy_q ? PH_RUN : PH_CAL;
		endcase
	end
	wire run = (phase_q == PH_RUN);

	// control registers
	logic [NCH-1:0] win_q;
	logic [NCH-1:0] filt_en_q;
	logic [31:0] int_mask_q;
	logic [31:0] int_stat_q;

	localparam logic [CNT_W-1:0] ON_LIM = CNT_W'(FILT_ON_CYC - 1);
	localparam logic [CNT_W-1:0] OFF_LIM = CNT_W'(FILT_OFF_CYC - 1);
	logic [NCMP-1:0] filt_w;
	genvar gi;
	generate
		for (gi = 0; gi < NCMP; gi++)
		begin : g_filt
			logic [CNT_W-1:0] cnt_q;
			logic f_q;
			wire [CNT_W-1:0] lim = filt_en_q[gi % NCH] ? ON_LIM : OFF_LIM;
			wire stable = (raw_q[gi] == f_q);
			always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
			begin
				if (!rst_n_q)
				begin
					cnt_q <= '0;
					f_q <= 1'b0;
				end
				else if (!run)
				begin
					cnt_q <= '0;
					f_q <= raw_q[gi];
				end
				else if (stable)
					cnt_q <= '0;
				else if (cnt_q >= lim)
				begin
					cnt_q <= '0;
					f_q <= raw_q[gi];
				end
				else
					cnt_q <= cnt_q + 1'b1;
			end
			assign filt_w[gi] = f_q;
		end
	endgenerate

	wire [NCH-1:0] f_upper = filt_w[NCH-1:0];
	wire [NCH-1:0] f_lower = filt_w[NCMP-1:NCH];
	// window is lower and not upper
	wire [NCH-1:0] window = f_lower & ~f_upper;
	wire [NCH-1:0] a_nx = run ? ((win_q & window) | (~win_q & f_upper)) : '0;
	// output B filtered lower, gated until ready
	wire [NCH-1:0] b_nx = run ? f_lower : '0;

	// events: output changes while valid, and ready reached
	wire [31:0] ev = {(phase_q == PH_CAL) && rdy_q, 5'h00, b_nx ^ STATUS_OUT.lower,
		6'h00, a_nx ^ STATUS_OUT.upper} & {1'b1, {31{run}}};

	// APB decode, one wait state
	wire acc = PSEL_IN && PENABLE_IN;
	wire done = acc && PREADY_OUT;
	wire sel_ctrl = hit(PADDR_IN, `VMS_OFF_CTRL);
	wire sel_stat = hit(PADDR_IN, `VMS_OFF_STATUS);
	wire sel_raw = hit(PADDR_IN, `VMS_OFF_RAW);
	wire sel_int = hit(PADDR_IN, `VMS_OFF_INT_STAT);
	wire sel_mask = hit(PADDR_IN, `VMS_OFF_INT_MASK);
	wire sel_info = hit(PADDR_IN, `VMS_OFF_INFO);
	wire mapped = sel_ctrl | sel_stat | sel_raw | sel_int | sel_mask | sel_info;
	wire wr = done && PWRITE_IN;
	wire rd_clr = done && !PWRITE_IN && sel_int;
	// clear only what the read returned, so a bit set during the access survives
	wire [31:0] int_stat_d = (int_stat_q & ~(rd_clr ? PRDATA_OUT : 32'h0000_0000)) | ev;
	wire [31:0] info_w = {6'h00, `VMS_HV_CHANNELS, 6'h00, `VMS_DIFF_CHANNELS};
	wire [31:0] ctrl_w = {6'h00, filt_en_q, 6'h00, win_q};
	wire [31:0] stat_w = {STATUS_VALID_OUT, 5'h00, STATUS_OUT.lower, 6'h00, STATUS_OUT.upper};
	wire [31:0] raw_w = {6'h00, raw_q[NCMP-1:NCH], 6'h00, raw_q[NCH-1:0]};
	wire [31:0] rd_w = ({32{sel_ctrl}} & ctrl_w) | ({32{sel_stat}} & stat_w)
		| ({32{sel_raw}} & raw_w) | ({32{sel_int}} & int_stat_q)
		| ({32{sel_mask}} & int_mask_q) | ({32{sel_info}} & info_w);

	always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			PREADY_OUT <= 1'b0;
			PRDATA_OUT <= 32'h0000_0000;
			PSLVERR_OUT <= 1'b0;
		end
		else
		begin
			PREADY_OUT <= acc && !PREADY_OUT;
			PRDATA_OUT <= (acc && !PREADY_OUT && !PWRITE_IN) ? rd_w : 32'h0000_0000;
			PSLVERR_OUT <= acc && !PREADY_OUT && !mapped;
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			win_q <= NCH'(`VMS_CTRL_RESET);
			filt_en_q <= '0;
			int_mask_q <= `VMS_MASK_RESET;
		end
		else if (wr && sel_ctrl)
		begin
			win_q <= PWDATA_IN[NCH-1:0];
			filt_en_q <= PWDATA_IN[`VMS_LOWER_LSB+NCH-1:`VMS_LOWER_LSB];
		end
		else if (wr && sel_mask)
			int_mask_q <= PWDATA_IN;
	end

	always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			phase_q <= PH_CAL;
			int_stat_q <= 32'h0000_0000;
			IRQ_OUT <= 1'b0;
			STATUS_OUT <= '0;
			STATUS_VALID_OUT <= 1'b0;
			FAST_CH4_OUT <= 1'b0;
			FAST_CH9_OUT <= 1'b0;
			GPO_OUT <= '0;
		end
		else
		begin
			phase_q <= phase_d;
			// set wins over read clear
			int_stat_q <= int_stat_d;
			IRQ_OUT <= |(int_stat_d & int_mask_q);
			STATUS_OUT <= '{lower: b_nx, upper: a_nx};
			STATUS_VALID_OUT <= run;
			// fast path uses detector A, not window
			FAST_CH4_OUT <= run && f_upper[`VMS_FAST_CH4];
			FAST_CH9_OUT <= run && f_upper[`VMS_FAST_CH9];
			GPO_OUT <= run ? GPO_REQ_IN : '0;
		end
	end
endmodule : vms_top

// >>> vms_defs.svh
// register offsets, field positions, reset values and timing constants
`ifndef VMS_DEFS_SVH
`define VMS_DEFS_SVH
`define VMS_CHANNELS 10
`define VMS_GPO_WIDTH 8
`define VMS_CLK_MHZ 250
`define VMS_FILT_ON_US 64
`define VMS_FILT_OFF_US 16
`define VMS_OFF_CTRL 8'h00
`define VMS_OFF_STATUS 8'h04
`define VMS_OFF_RAW 8'h08
`define VMS_OFF_INT_STAT 8'h0C
`define VMS_OFF_INT_MASK 8'h10
`define VMS_OFF_INFO 8'h14
`define VMS_LOWER_LSB 16
`define VMS_READY_BIT 31
`define VMS_CTRL_RESET 32'h0000_0000
`define VMS_MASK_RESET 32'h0000_0000
`define VMS_DIFF_CHANNELS 10'h00F
`define VMS_HV_CHANNELS 10'h200
`define VMS_FAST_CH4 3
`define VMS_FAST_CH9 8
`endif

// >>> vms_pkg.sv
// types shared by the voltage monitor status logic
`include "vms_defs.svh"
package vms_pkg;
	typedef struct packed {
		logic [`VMS_CHANNELS-1:0] lower;
		logic [`VMS_CHANNELS-1:0] upper;
	} vms_cmp_t;
	typedef enum logic {PH_CAL, PH_RUN} vms_phase_t;
endpackage : vms_pkg

// >>> vms_props.sv
// bound checker on the voltage monitor status ports
`timescale 1ns/1ps
module vms_props #(parameter int unsigned GPO_WIDTH = 8) (
	input wire logic CLK_SYS_IN,
	input wire logic NRST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire vms_pkg::vms_cmp_t STATUS_OUT,
	input wire logic STATUS_VALID_OUT,
	input wire logic FAST_CH4_OUT,
	input wire logic FAST_CH9_OUT,
	input wire logic [GPO_WIDTH-1:0] GPO_REQ_IN,
	input wire logic [GPO_WIDTH-1:0] GPO_OUT
);
	import vms_pkg::*;
	default clocking cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (!NRST_IN);
	// two idle cycles asked, so a one-cycle skew against valid is tolerated
	a_status_gate: assert property (
		!STATUS_VALID_OUT && !$past(STATUS_VALID_OUT) |-> STATUS_OUT == '0) else $error("status early");
	a_fast_gate: assert property (
		!STATUS_VALID_OUT && !$past(STATUS_VALID_OUT) |-> !FAST_CH4_OUT && !FAST_CH9_OUT)
		else $error("fast output early");
	a_gpo_gate: assert property (
		!STATUS_VALID_OUT && !$past(STATUS_VALID_OUT) |-> GPO_OUT == '0) else $error("gpo early");
	a_gpo_follow: assert property (
		STATUS_VALID_OUT && $past(STATUS_VALID_OUT) |-> GPO_OUT == $past(GPO_REQ_IN))
		else $error("gpo not forwarded");
	a_ready_wait: assert property (
		PSEL_IN && !PENABLE_IN |=> !PREADY_OUT ##1 PREADY_OUT) else $error("wait state wrong");
	a_ready_one: assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready long");
	a_ready_access: assert property (
		PREADY_OUT |-> PSEL_IN && PENABLE_IN) else $error("ready outside access");
	a_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT) else $error("error alone");
endmodule : vms_props
bind vms_top vms_props #(.GPO_WIDTH(GPO_WIDTH)) vms_props_i (.CLK_SYS_IN(CLK_SYS_IN),
	.NRST_IN(NRST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .STATUS_OUT(STATUS_OUT), .STATUS_VALID_OUT(STATUS_VALID_OUT),
	.FAST_CH4_OUT(FAST_CH4_OUT), .FAST_CH9_OUT(FAST_CH9_OUT), .GPO_REQ_IN(GPO_REQ_IN),
	.GPO_OUT(GPO_OUT));

// >>> vms_fabric_model.sv
// fabric-side model: output control requests that change every cycle
`timescale 1ns/1ps
module vms_fabric_model #(parameter int unsigned W = 8) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	output logic [W-1:0] gpo_req_out
);
	// johnson pattern, so a stale or stuck forward shows at once
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			gpo_req_out <= '0;
		else
			gpo_req_out <= {gpo_req_out[W-2:0], ~gpo_req_out[W-1]};
	end
endmodule : vms_fabric_model

// >>> testbench.sv
// self-checking bench for the voltage monitor status logic
`timescale 1ns/1ps
`include "vms_defs.svh"
module testbench;
	import vms_pkg::*;
	localparam logic [31:0] zero = 32'h0000_0000;
	logic clk = 0, nrst = 0, rdy = 0, psel = 0, pen = 0, pw = 0, pready, perr, er, sv, f4, f9, irq;
	logic [7:0] pa = 8'h00, req, gpo, prev;
	logic [31:0] pd = zero, prd, v;
	logic [19:0] wraw [3] = '{20'h0_0400, 20'h0_0401, 20'h0_0000};
	logic [19:0] wexp [3] = '{20'h0_0401, 20'h0_0400, 20'h0_0000};
	vms_cmp_t raw = '0, st;
	int mismatches = 0, n_checks = 0, cyc = 0;
	vms_top #(.FILT_ON_CYC(16), .FILT_OFF_CYC(4)) vms_top_i (.CLK_SYS_IN(clk), .NRST_IN(nrst),
		.CMP_RAW_IN(raw), .ANALOG_READY_IN(rdy), .GPO_REQ_IN(req), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pw), .PADDR_IN(pa), .PWDATA_IN(pd), .PRDATA_OUT(prd),
		.PREADY_OUT(pready), .PSLVERR_OUT(perr), .STATUS_OUT(st), .STATUS_VALID_OUT(sv),
		.FAST_CH4_OUT(f4), .FAST_CH9_OUT(f9), .GPO_OUT(gpo), .IRQ_OUT(irq));
	vms_fabric_model vms_fabric_model_i (.clk_in(clk), .rst_n_in(nrst), .gpo_req_out(req));
	initial forever #2 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			mismatches++;
			results();
		end
	end
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] s, input logic [31:0] x, input string n);
		n_checks++;
		if (s !== x)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pw <= w;
		pa <= a;
		pd <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		v = prd;
		er = perr;
		psel <= 0;
		pen <= 0;
	endtask : bus
	task automatic step(input logic [19:0] r, input int n, input logic [19:0] x);
		@(posedge clk);
		raw <= r;
		repeat (n) @(posedge clk);
		#1 chk(32'(st), 32'(x), "status");
	endtask : step
	initial
	begin
		repeat (3) @(posedge clk);
		nrst <= 1;
		step(20'hF_FFFF, 12, 20'h0_0000);
		chk(32'(gpo), zero, "gpo");
		step(20'h0_0000, 12, 20'h0_0000);
		rdy <= 1;
		while (sv !== 1'b1) @(posedge clk);
		bus(0, `VMS_OFF_INT_STAT, zero);
		chk(v, 32'h8000_0000, "ready event");
		bus(0, `VMS_OFF_INFO, zero);
		chk(v, 32'h0200_000F, "info");
		$display("test calibration done");
		step(20'h0_0001, 2, 20'h0_0000);
		step(20'h0_0000, 10, 20'h0_0000);
		step(20'h0_0001, 4, 20'h0_0000);
		step(20'h0_0001, 8, 20'h0_0001);
		step(20'hF_FFFF, 12, 20'hF_FFFF);
		chk(32'({f9, f4}), 32'h0000_0003, "fast");
		chk(32'(sv), 32'h0000_0001, "valid");
		bus(0, `VMS_OFF_STATUS, zero);
		chk(v, 32'h83FF_03FF, "status reg");
		bus(0, `VMS_OFF_RAW, zero);
		chk(v, 32'h03FF_03FF, "raw reg");
		step(20'h0_0008, 12, 20'h0_0008);
		chk(32'({f9, f4}), 32'h0000_0001, "fast");
		step(20'h0_0000, 12, 20'h0_0000);
		bus(1, `VMS_OFF_CTRL, 32'h0001_0000);
		step(20'h0_0001, 12, 20'h0_0000);
		step(20'h0_0000, 12, 20'h0_0000);
		step(20'h0_0001, 12, 20'h0_0000);
		step(20'h0_0001, 20, 20'h0_0001);
		step(20'h0_0000, 12, 20'h0_0001);
		step(20'h0_0000, 20, 20'h0_0000);
		$display("test filter done");
		// threshold A kept above B, so A high with B low is never applied
		bus(1, `VMS_OFF_CTRL, 32'h0000_0001);
		for (int i = 0; i < 3; i++) step(wraw[i], 12, wexp[i]);
		$display("test window done");
		bus(0, `VMS_OFF_INT_STAT, zero);
		bus(1, `VMS_OFF_CTRL, zero);
		bus(1, `VMS_OFF_INT_MASK, 32'h0000_0001);
		step(20'h0_0001, 12, 20'h0_0001);
		chk(32'(irq), 32'h0000_0001, "irq");
		bus(0, `VMS_OFF_INT_STAT, zero);
		chk(v, 32'h0000_0001, "int stat");
		repeat (2) @(posedge clk);
		#1 chk(32'(irq), zero, "irq cleared");
		bus(1, `VMS_OFF_INT_MASK, 32'h0001_0000);
		step(20'h0_0000, 12, 20'h0_0000);
		chk(32'(irq), zero, "irq masked");
		$display("test interrupt done");
		bus(0, 8'h18, zero);
		chk(v, zero, "unmapped data");
		chk(32'(er), 32'h0000_0001, "unmapped error");
		bus(1, `VMS_OFF_INFO, 32'hFFFF_FFFF);
		bus(0, `VMS_OFF_INFO, zero);
		chk(v, 32'h0200_000F, "info kept");
		@(posedge clk);
		#1 prev = req;
		@(posedge clk);
		#1 chk(32'(gpo), 32'(prev), "gpo");
		$display("test bus done");
		results();
	end
endmodule : testbench
